/* rtl/crcg_consts.svh */
// Purpose: offsets, field positions, codes and reset values
// Assumes: included by bare name from the package and the top
// Notes: register index times four is the byte address
`ifndef CRCG_CONSTS_SVH
`define CRCG_CONSTS_SVH
`define CRCG_AW 8
`define CRCG_IDX_CONTROL 3'h0
`define CRCG_IDX_FLAGS 3'h2
`define CRCG_IDX_INPUT 3'h3
`define CRCG_IDX_SUM0 3'h4
`define CRCG_BIT_RST_HI 7
`define CRCG_BIT_RST_LO 6
`define CRCG_BIT_WIDE 5
`define CRCG_BIT_BUSY 0
`define CRCG_BIT_ZERO 1
`define CRCG_SRC_RSVD 4'h3
`define CRCG_POLY16 16'h1021
`define CRCG_POLY32 32'h04c11db7
`define CRCG_SRC_OFF 4'h0
`define CRCG_SRC_REG 4'h1
`define CRCG_SRC_NVM 4'h2
`define CRCG_SRC_CH0 4'h4
`define CRCG_SRC_CH1 4'h5
`define CRCG_SRC_CH2 4'h6
`define CRCG_SRC_CH3 4'h7
`define CRCG_SUM_ZEROS 32'h00000000
`define CRCG_SUM_ONES 32'hffffffff
`define CRCG_RESP_OKAY 2'h0
`define CRCG_RESP_SLVERR 2'h2
`endif

/* rtl/crcg_pkg.sv */
// Purpose: types shared by the generator and its bench
// Assumes: constants come from crcg_consts.svh
// Notes: source codes follow the control register field
`include "crcg_consts.svh"
package crcg_pkg;
  // input source selection
  typedef enum logic [3:0] {
    SRC_OFF = `CRCG_SRC_OFF,
    SRC_REG = `CRCG_SRC_REG,
    SRC_NVM = `CRCG_SRC_NVM,
    SRC_CH0 = `CRCG_SRC_CH0,
    SRC_CH1 = `CRCG_SRC_CH1,
    SRC_CH2 = `CRCG_SRC_CH2,
    SRC_CH3 = `CRCG_SRC_CH3
  } crcg_src_t;

  // bytes and end pulses from the four dma channels
  typedef struct packed {
    logic [3:0] valid;
    logic [3:0][7:0] data;
    logic [3:0] finish;
  } crcg_dma_t;

  // bytes and end pulse from the nonvolatile_controller
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic finish;
  } crcg_nvm_t;

  // whole state of the generator
  typedef struct packed {
    logic [31:0] sum;
    logic wide;
    crcg_src_t src;
    logic busy;
    logic zero;
    logic rst_pend;
    logic rst_fill;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crcg_state_t;
endpackage

/* rtl/crcg_top.sv */
// Purpose: byte-wide crc generator with an axi4-lite register slave
// Assumes: dma and nonvolatile_controller inputs run on core_clk
// Notes: one write and one read under way at a time
//
// How it works
// - two polynomials, 16-bit 0x1021 and 32-bit 0x04c11db7
// - control bit 5 selects the 32-bit polynomial, 16-bit by default
// - polynomial select write ignored while busy
// - flash source always uses the 32-bit polynomial
// - input folded one byte at a time, one update per byte
// - 32-bit result reads bit reversed and complemented
// - reset field: 00 none, 01 reserved, 10 zeros, 11 ones
// - reset field reads zero, registers reset one cycle after write
// - source codes: off, register, flash, dma channels 0 to 3
// - chosen source locked until calculation completes or reset
// - selected dma channel bytes folded; result valid at its end
// - byte input register takes any number of bytes, one per write, at most one write every three cycles
// - updated checksum available one cycle after a byte input write
// - busy reads one while the selected source uses the generator
// - busy clears by software, dma end, or flash completion
// - zero flag set on zero result at completion, cleared on select
// - 32-bit residue over data plus appended checksum as specified
// - reversed view only for 32-bit and not busy, else raw value
// - flash source reads checksum as zero while busy
// - checksum bytes reset to zero, writable only when disabled
`timescale 1ns/1ps
`include "crcg_consts.svh"
module crcg_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [`CRCG_AW-1:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [`CRCG_AW-1:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  input wire crcg_pkg::crcg_dma_t dma_in,
  input wire crcg_pkg::crcg_nvm_t nvm_in
);
  crcg_pkg::crcg_state_t q;
  crcg_pkg::crcg_state_t n;

  // one byte through the shift register, msb-first feedback
  function automatic logic [31:0] crcg_step(
    input logic [31:0] s,
    input logic [7:0] b,
    input logic wide
  );
    logic [31:0] r;
    logic fb;
    integer i;
    r = s;
    for (i = 0; i < 8; i++)
    begin
      if (wide)
      begin
        // 32-bit takes data lsb first, hence the reversed readout
        fb = r[31] ^ b[i];
        r = {r[30:0], 1'b0} ^ (fb ? `CRCG_POLY32 : 32'h00000000);
      end
      else
      begin
        fb = r[15] ^ b[7-i];
        r[15:0] = {r[14:0], 1'b0} ^ (fb ? `CRCG_POLY16 : 16'h0000);
      end
    end
    return r;
  endfunction

  // mirror of all 32 bits
  function automatic logic [31:0] crcg_rev(input logic [31:0] s);
    logic [31:0] r;
    integer i;
    r = 32'h00000000;
    for (i = 0; i < 32; i++)
    begin
      r[i] = s[31-i];
    end
    return r;
  endfunction

  // what a reader sees of the running value
  function automatic logic [31:0] crcg_view(
    input logic [31:0] s,
    input logic wide,
    input logic nonvolatile_controller,
    input logic busy
  );
    logic [31:0] r;
    r = s;
    if (nonvolatile_controller && busy)
    begin
      r = 32'h00000000;
    end
    else if (wide && !busy)
    begin
      r = ~crcg_rev(s);
    end
    return r;
  endfunction

  logic [2:0] w_idx;
  logic [2:0] r_idx;
  logic w_map;
  logic r_map;
  logic wr_go;
  logic rd_go;
  logic wr_ctl;
  logic wr_flg;
  logic wr_in;
  logic wr_sum;
  logic [7:0] w_byte;
  logic wide_eff;
  logic src_is_ch;
  logic [1:0] ch;
  logic fold_reg;
  logic fold_ch;
  logic fold_nvm;
  logic fold;
  logic [7:0] fold_val;
  logic done;
  logic [31:0] sum_fold;
  logic [3:0] src_new;
  logic src_legal;

  // address decode; anything above index 7 is unmapped
  assign w_idx = s_awaddr[4:2];
  assign r_idx = s_araddr[4:2];
  assign w_map = (s_awaddr[`CRCG_AW-1:5] == 3'h0);
  assign r_map = (s_araddr[`CRCG_AW-1:5] == 3'h0);
  assign wr_go = q.awready & s_awvalid & s_wvalid;
  assign rd_go = q.arready & s_arvalid;
  assign w_byte = s_wdata[7:0];
  // registers are one byte wide, so only lane 0 writes
  assign wr_ctl = wr_go & w_map & s_wstrb[0] &
    (w_idx == `CRCG_IDX_CONTROL);
  assign wr_flg = wr_go & w_map & s_wstrb[0] &
    (w_idx == `CRCG_IDX_FLAGS);
  assign wr_in = wr_go & w_map & s_wstrb[0] &
    (w_idx == `CRCG_IDX_INPUT);
  assign wr_sum = wr_go & w_map & s_wstrb[0] & w_idx[2];

  // flash forces the wide polynomial whatever the bit holds
  assign wide_eff = q.wide | (q.src == crcg_pkg::SRC_NVM);
  assign src_is_ch = (q.src[3:2] == 2'b01);
  assign ch = q.src[1:0];

  // byte folding from the selected source only
  assign fold_reg = wr_in & (q.src == crcg_pkg::SRC_REG) & q.busy;
  assign fold_ch = src_is_ch & q.busy & dma_in.valid[ch];
  assign fold_nvm = (q.src == crcg_pkg::SRC_NVM) & q.busy & nvm_in.valid;
  assign fold = fold_reg | fold_ch | fold_nvm;
  assign fold_val = fold_reg ? w_byte :
    (fold_ch ? dma_in.data[ch] : nvm_in.data);
  assign sum_fold = fold ?
    crcg_step(q.sum, fold_val, wide_eff) : q.sum;

  // completion: software for register source, far end otherwise
  assign done = q.busy & (
    (wr_flg & s_wdata[`CRCG_BIT_BUSY] & (q.src == crcg_pkg::SRC_REG)) |
    (src_is_ch & dma_in.finish[ch]) |
    ((q.src == crcg_pkg::SRC_NVM) & nvm_in.finish));

  // reserved and undefined source codes are dropped
  assign src_new = w_byte[3:0];
  assign src_legal = !src_new[3] && (src_new != `CRCG_SRC_RSVD);

  // next state
  always_comb
  begin
    logic [31:0] fin;
    fin = 32'h00000000;
    n = q;
    n.sum = sum_fold;
    // write channel: take address and data together, one at a time
    n.awready = !q.awready && !q.bvalid && s_awvalid && s_wvalid;
    n.wready = !q.awready && !q.bvalid && s_awvalid && s_wvalid;
    if (q.bvalid && s_bready)
    begin
      n.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      n.bvalid = 1'b1;
      n.bresp = w_map ? `CRCG_RESP_OKAY : `CRCG_RESP_SLVERR;
    end
    if (wr_ctl)
    begin
      if (!q.busy)
      begin
        n.wide = w_byte[`CRCG_BIT_WIDE];
      end
      if (!q.busy && src_legal)
      begin
        // selection locked while busy
        n.src = crcg_pkg::crcg_src_t'(src_new);
        n.busy = (src_new != `CRCG_SRC_OFF);
        n.zero = 1'b0;
      end
      // 01 is reserved and does nothing
      if (w_byte[`CRCG_BIT_RST_HI])
      begin
        n.rst_pend = 1'b1;
        n.rst_fill = w_byte[`CRCG_BIT_RST_LO];
      end
    end
    if (wr_sum && (q.src == crcg_pkg::SRC_OFF))
    begin
      n.sum[{w_idx[1:0], 3'b000} +: 8] = w_byte;
    end
    // completion comes after selection so a set is never lost
    if (done)
    begin
      n.busy = 1'b0;
      fin = crcg_view(sum_fold, wide_eff, 1'b0, 1'b0);
      n.zero = wide_eff ? (fin == 32'h00000000) :
        (fin[15:0] == 16'h0000);
    end
    // deferred module reset overrides every other sum, control and flag update
    if (q.rst_pend)
    begin
      n.sum = q.rst_fill ? `CRCG_SUM_ONES : `CRCG_SUM_ZEROS;
      n.wide = 1'b0;
      n.src = crcg_pkg::SRC_OFF;
      n.busy = 1'b0;
      n.zero = 1'b0;
      n.rst_pend = 1'b0;
      n.rst_fill = 1'b0;
    end
    // read channel: one read at a time
    n.arready = !q.arready && !q.rvalid && s_arvalid;
    if (q.rvalid && s_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (rd_go)
    begin
      n.rvalid = 1'b1;
      n.rresp = r_map ? `CRCG_RESP_OKAY : `CRCG_RESP_SLVERR;
      fin = crcg_view(q.sum, wide_eff,
        q.src == crcg_pkg::SRC_NVM, q.busy);
      n.rdata = 32'h00000000;
      if (r_map)
      begin
        case (r_idx)
          `CRCG_IDX_CONTROL:
            n.rdata[7:0] = {2'b00, q.wide, 1'b0, q.src};
          `CRCG_IDX_FLAGS:
            n.rdata[7:0] = {6'h00, q.zero, q.busy};
          `CRCG_IDX_SUM0, 3'h5, 3'h6, 3'h7:
            n.rdata[7:0] = fin[{r_idx[1:0], 3'b000} +: 8];
          default:
            n.rdata[7:0] = 8'h00;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign s_awready = q.awready;
  assign s_wready = q.wready;
  assign s_bvalid = q.bvalid;
  assign s_bresp = q.bresp;
  assign s_arready = q.arready;
  assign s_rvalid = q.rvalid;
  assign s_rdata = q.rdata;
  assign s_rresp = q.rresp;

  // polynomial cannot move during a calculation
  property p_poly_hold;
    @(posedge core_clk) disable iff (rst)
    (q.busy && !q.rst_pend) |=> (q.wide == $past(q.wide));
  endproperty
  a_poly_hold: assert property (p_poly_hold)
    else $error("polynomial changed while busy");

  // source held while busy
  property p_src_lock;
    @(posedge core_clk) disable iff (rst)
    (q.busy && !q.rst_pend) |=> (q.src == $past(q.src));
  endproperty
  a_src_lock: assert property (p_src_lock)
    else $error("source changed while busy");

  // reset command lands two edges after the write
  property p_rst_apply;
    @(posedge core_clk) disable iff (rst)
    (wr_ctl && s_wdata[7] && !q.rst_pend) |=> q.rst_pend ##1
    (q.sum == {32{$past(s_wdata[6], 2)}} && !q.busy &&
    q.src == crcg_pkg::SRC_OFF);
  endproperty
  a_rst_apply: assert property (p_rst_apply)
    else $error("reset command not applied on time");

  // byte input outside a register calculation does nothing
  property p_input_ignored;
    @(posedge core_clk) disable iff (rst)
    (wr_in && !(q.src == crcg_pkg::SRC_REG && q.busy) &&
    !fold && !q.rst_pend && !wr_sum) |=> $stable(q.sum);
  endproperty
  a_input_ignored: assert property (p_input_ignored)
    else $error("ignored byte input changed checksum");

  // register-fed byte shows one cycle later
  property p_byte_next;
    @(posedge core_clk) disable iff (rst)
    (fold_reg && !q.rst_pend) |=>
    (q.sum == crcg_step($past(q.sum), $past(w_byte), $past(wide_eff)));
  endproperty
  a_byte_next: assert property (p_byte_next)
    else $error("checksum not updated after byte input");

  // software write of one clears busy for register source
  property p_reg_done;
    @(posedge core_clk) disable iff (rst)
    (wr_flg && s_wdata[0] && q.busy && q.src == crcg_pkg::SRC_REG)
    |=> !q.busy;
  endproperty
  a_reg_done: assert property (p_reg_done)
    else $error("busy not cleared by software");

  // dma channel end clears busy
  property p_dma_done;
    @(posedge core_clk) disable iff (rst)
    (src_is_ch && q.busy && dma_in.finish[ch]) |=> !q.busy;
  endproperty
  a_dma_done: assert property (p_dma_done)
    else $error("busy not cleared at dma end");

  // flash checksum hidden while busy
  property p_nvm_hidden;
    @(posedge core_clk) disable iff (rst)
    (rd_go && r_map && r_idx[2] && q.busy &&
    q.src == crcg_pkg::SRC_NVM) |=> (s_rvalid && s_rdata == 32'h0);
  endproperty
  a_nvm_hidden: assert property (p_nvm_hidden)
    else $error("flash checksum visible while busy");

  // legal selection other than off sets busy and clears zero
  property p_select;
    @(posedge core_clk) disable iff (rst)
    (wr_ctl && !q.busy && src_legal && src_new != 4'h0 &&
    !s_wdata[7] && !q.rst_pend) |=> (q.busy && !q.zero);
  endproperty
  a_select: assert property (p_select)
    else $error("selection did not set busy or clear zero");

  // checksum writes refused unless disabled
  property p_sum_locked;
    @(posedge core_clk) disable iff (rst)
    (wr_sum && q.src != crcg_pkg::SRC_OFF && !q.busy &&
    !q.rst_pend) |=> $stable(q.sum);
  endproperty
  a_sum_locked: assert property (p_sum_locked)
    else $error("checksum written while a source is selected");

  // reset field and reserved bit read zero
  property p_ctl_read;
    @(posedge core_clk) disable iff (rst)
    (rd_go && r_map && r_idx == 3'h0) |=>
    (s_rvalid && s_rdata[7:6] == 2'b00 && !s_rdata[4]);
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("reserved control bits read nonzero");
endmodule // crcg_top

/* testbench/crcg_far_model.sv */
// Purpose: stand-in for the dma channels and the nonvolatile_controller
// Assumes: the bench issues one burst at a time
// Notes: released lanes show the inverse of their last byte
`timescale 1ns/1ps
module crcg_far_model (
  input wire logic core_clk,
  output crcg_pkg::crcg_dma_t dma_out,
  output crcg_pkg::crcg_nvm_t nvm_out
);
  // quiet lanes from time zero
  initial
  begin
    dma_out = '0;
    nvm_out = '0;
  end

  // all lanes busy so unselected channels act as noise
  task automatic dma_burst(input int ch, input logic [7:0] q[$]);
    logic [3:0][7:0] d;
    foreach (q[i])
    begin
      for (int k = 0; k < 4; k++)
        d[k] = (k == ch) ? q[i] : ~q[i];
      @(posedge core_clk);
      dma_out.valid <= 4'hf;
      dma_out.data <= d;
      // end of transaction rides with the last byte
      dma_out.finish <= (i == q.size() - 1) ? 4'h1 << ch : 4'h0;
    end
    @(posedge core_clk);
    dma_out.valid <= 4'h0;
    dma_out.finish <= 4'h0;
    dma_out.data <= ~d; // no stale byte left on the lanes
  endtask

  // range and launch are settled on the controller side
  task automatic nvm_burst(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      @(posedge core_clk);
      nvm_out.valid <= 1'b1;
      nvm_out.data <= q[i];
      nvm_out.finish <= (i == q.size() - 1);
    end
    @(posedge core_clk);
    nvm_out.valid <= 1'b0;
    nvm_out.finish <= 1'b0;
    nvm_out.data <= ~q[q.size() - 1];
  endtask
endmodule // crcg_far_model

/* testbench/crcg_top_tb.sv */
// Purpose: self-checking bench for the crc generator
// Assumes: bready and rready stay high, full write strobes
// Notes: expected sums come from the bench's own crc steps
`timescale 1ns/1ps
module crcg_top_tb;
  logic core_clk, rst, s_awvalid, s_awready, s_wvalid, s_wready;
  logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, s, r, got;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, resp;
  crcg_pkg::crcg_dma_t dma_in;
  crcg_pkg::crcg_nvm_t nvm_in;
  int mismatches, samples_checked;
  logic [7:0] msg [$];
  // rows: register index then expected response, all read zero
  logic [9:0] rows [8] = '{10'h000, 10'h010, 10'h020, 10'h040,
    10'h050, 10'h060, 10'h070, 10'h082};

  crcg_top u_dut (.core_clk(core_clk), .rst(rst),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_bresp(s_bresp), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_araddr(s_araddr), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .dma_in(dma_in), .nvm_in(nvm_in));
  crcg_far_model u_far (.core_clk(core_clk), .dma_out(dma_in),
    .nvm_out(nvm_in));

  // 16-bit step, msb of the byte first
  function automatic logic [31:0] step16(logic [31:0] v, logic [7:0] b);
    logic [15:0] c;
    c = v[15:0];
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return {v[31:16], c};
  endfunction

  // 32-bit step, lsb of the byte first
  function automatic logic [31:0] step32(logic [31:0] v, logic [7:0] b);
    for (int i = 0; i < 8; i++)
      v = {v[30:0], 1'b0} ^ ((v[31] ^ b[i]) ? 32'h04c11db7 : 32'h0);
    return v;
  endfunction

  // reader's view of a finished 32-bit sum
  function automatic logic [31:0] view32(logic [31:0] v);
    logic [31:0] o;
    for (int i = 0; i < 32; i++)
      o[i] = ~v[31 - i];
    return o;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_awaddr <= a;
    s_wdata <= {24'h000000, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do @(posedge core_clk); while (s_awready !== 1'b1);
    s_awvalid <= 1'b0;
    s_wvalid <= 1'b0;
    do @(posedge core_clk); while (s_bvalid !== 1'b1);
    resp = s_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge core_clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    resp = s_rresp;
  endtask

  // four checksum bytes gathered into one word
  task automatic rdsum(output logic [31:0] v);
    logic [31:0] t;
    for (int k = 0; k < 4; k++)
    begin
      rd(8'(16 + 4 * k), t);
      v[8 * k +: 8] = t[7:0];
    end
  endtask

  task end_sim;
    $display("checked %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // watchdog well beyond the several hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end

  initial
  begin
    {rst, s_awvalid, s_wvalid, s_arvalid} = 4'h8;
    {s_bready, s_rready, s_wstrb} = 6'h3f;
    {s_awaddr, s_araddr, s_wdata} = '0;
    for (int i = 0; i < 9; i++)
      msg.push_back(8'h31 + 8'(i));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // reset values and the unmapped place
    foreach (rows[i])
    begin
      rd({rows[i][9:4], 2'h0}, got);
      chk("reset read", 32'h0, got);
      chk("rresp", {30'h0, rows[i][1:0]}, {30'h0, resp});
    end
    // unmapped write is refused with an error response
    wr(8'h20, 8'h00);
    chk("bresp", 32'h2, {30'h0, resp});
    $display("test reset map done");
    // register source, default 16-bit
    wr(8'h00, 8'h01);
    rd(8'h08, got);
    chk("busy", 32'h1, got);
    s = 32'h0;
    foreach (msg[i])
    begin
      wr(8'h0c, msg[i]);
      s = step16(s, msg[i]);
    end
    rdsum(got);
    chk("sum16 raw", s, got);
    r = s;
    wr(8'h0c, r[15:8]);
    wr(8'h0c, r[7:0]);
    s = step16(step16(s, r[15:8]), r[7:0]);
    wr(8'h08, 8'h01);
    rd(8'h08, got);
    chk("flags", {30'h0, s[15:0] == 16'h0, 1'b0}, got);
    wr(8'h0c, 8'h5a);
    wr(8'h10, 8'ha5);
    rdsum(got);
    chk("idle sum", s, got);
    wr(8'h00, 8'h13);
    rd(8'h08, got);
    chk("flags kept", 32'h2, got);
    rd(8'h00, got);
    chk("control", 32'h01, got);
    wr(8'h00, 8'h00);
    wr(8'h10, 8'ha5);
    rd(8'h10, got);
    chk("sum byte", 32'ha5, got);
    wr(8'h00, 8'h01);
    rd(8'h08, got);
    chk("flags", 32'h1, got);
    wr(8'h08, 8'h01);
    $display("test register source 16 done");
    // 32-bit from all ones, then the appended residue
    wr(8'h00, 8'hc0);
    wr(8'h00, 8'h21);
    rd(8'h00, got);
    chk("control", 32'h21, got);
    wr(8'h00, 8'h01);
    rd(8'h00, got);
    chk("control", 32'h21, got);
    s = 32'hffffffff;
    foreach (msg[i])
    begin
      wr(8'h0c, msg[i]);
      s = step32(s, msg[i]);
    end
    rdsum(got);
    chk("sum32 raw", s, got);
    wr(8'h08, 8'h01);
    r = view32(s);
    rdsum(got);
    chk("sum32 view", r, got);
    wr(8'h00, 8'h21);
    for (int k = 0; k < 4; k++)
      wr(8'h0c, r[8 * k +: 8]);
    wr(8'h08, 8'h01);
    rdsum(got);
    chk("residue", 32'h2144df1c, got);
    // keep the wide bit so the reversed view stays in force
    wr(8'h00, 8'h60);
    rdsum(got);
    chk("reserved reset", 32'h2144df1c, got);
    wr(8'h00, 8'h80);
    rdsum(got);
    chk("zeroed sum", 32'h0, got);
    $display("test register source 32 done");
    // each dma channel with noise on the others
    for (int ch = 0; ch < 4; ch++)
    begin
      wr(8'h00, 8'h80);
      wr(8'h00, 8'(4 + ch));
      u_far.dma_burst(ch, msg);
      s = 32'h0;
      foreach (msg[i])
        s = step16(s, msg[i]);
      rd(8'h08, got);
      chk("dma flags", 32'h0, got);
      rdsum(got);
      chk("dma sum", s, got);
    end
    $display("test dma done");
    // flash scan forces 32-bit and hides the sum while busy
    wr(8'h00, 8'hc0);
    wr(8'h00, 8'h02);
    rdsum(got);
    chk("flash busy sum", 32'h0, got);
    u_far.nvm_burst(msg);
    s = 32'hffffffff;
    foreach (msg[i])
      s = step32(s, msg[i]);
    rd(8'h08, got);
    chk("flash flags", 32'h0, got);
    rdsum(got);
    chk("flash sum", view32(s), got);
    $display("test flash done");
    end_sim();
  end
endmodule // crcg_top_tb
